// *** logic/cmpb_params.svh ***
// register offsets, field positions and reset values for the comparator-b control block
// assumes a 32-bit avalon slave with word-aligned registers
`ifndef CMPB_PARAMS_SVH
`define CMPB_PARAMS_SVH
`define CMPB_ADDR_W          4
`define CMPB_OFF_CTRL        4'h0
`define CMPB_OFF_AUX         4'h4
`define CMPB_OFF_PORT        4'h8
`define CMPB_OFF_ANSEL       4'hC
`define CMPB_BIT_ON          7
`define CMPB_BIT_RESULT      6
`define CMPB_BIT_PIN_DRIVE   5
`define CMPB_BIT_INVERT      4
`define CMPB_BIT_REF_SEL     2
`define CMPB_BIT_NEG_HI      1
`define CMPB_BIT_NEG_LO      0
`define CMPB_BIT_MIRROR_A    7
`define CMPB_BIT_MIRROR_B    6
`define CMPB_BIT_GATE_SRC    1
`define CMPB_BIT_SYNC_SEL    0
`define CMPB_CTRL_RST        8'h00
`define CMPB_AUX_RST         8'h02
`define CMPB_CTRL_WMASK      8'hB7
`define CMPB_AUX_WMASK       8'h03
`define CMPB_PORT_W          8
`endif

// *** logic/cmpb_pkg.sv ***
// types for the comparator-b control block
// assumes cmpb_params.svh is included by the design files
package cmpb_pkg;
  typedef logic [7:0] cmpb_byte_t;
  typedef enum logic [0:0]
  {
    CMPB_IDLE = 1'b0,
    CMPB_ACK  = 1'b1
  } cmpb_bus_state_t;
endpackage

// *** logic/cmpb_edge_det.sv ***
// synchroniser with rising and falling edge detection for one external level
// assumes the input is asynchronous to core_clk
module cmpb_edge_det
(
  input  wire logic core_clk, // system clock
  input  wire logic rst,      // async reset, active high
  input  wire logic din,      // asynchronous level
  output logic      level,    // synchronised level
  output logic      rise,     // one-cycle pulse on rising edge
  output logic      fall      // one-cycle pulse on falling edge
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;
endmodule

// *** logic/cmpb_ctrl.sv ***
// control side of comparator b: control/aux registers, result polarity, pin gating,
// timer gate source with optional capture on the falling timer clock edge
// assumes analog comparison arrives as a raw level; timer clock and pins are asynchronous
//
// Design decisions made here: the address map and the Avalon-MM register port.
`include "cmpb_params.svh"
// Behaviour
// - result drives pin only with pin-drive 1, on 1, direction bit 0
// - gate source select cleared makes comparator b the timer gate
// - comparator gating acts only while timer is on and gating enabled
// - with sync on, capture comparator b output on falling timer clock edge
// - capture uses the prescaled timer clock when prescaler is in use
// - timer advances on rising edge, capture on falling edge, never together
// - port reads return 0 for every pin set as analog input
// - sync bit 1 selects registered output, 0 the asynchronous output
// - gate source bit 1 selects gate pin, 0 comparator; resets to 1
// - any reset returns both control registers to off defaults
module cmpb_ctrl #(
  parameter int PORT_W = `CMPB_PORT_W
)
(
  input  wire logic              core_clk,         // 20 MHz system clock
  input  wire logic              rst,              // async reset, active high
  input  wire logic [3:0]        avs_address,      // byte address
  input  wire logic              avs_read,         // read request
  input  wire logic              avs_write,        // write request
  input  wire logic [31:0]       avs_writedata,    // write data
  input  wire logic [3:0]        avs_byteenable,   // byte enables
  output logic      [31:0]       avs_readdata,     // read data
  output logic                   avs_waitrequest,  // stall
  input  wire logic              cmp_raw,          // analog comparison, plus above minus
  input  wire logic              cmp_a_result,     // comparator a result for mirror
  input  wire logic              port_direction_bit, // direction of comparator b pin
  input  wire logic              timer_clk,        // timer clock source, raw
  input  wire logic              timer_presc_clk,  // timer clock after prescaler
  input  wire logic              timer_presc_used, // prescaler in use
  input  wire logic              timer_on,         // timer switched on
  input  wire logic              timer_gate_en,    // timer gate function enabled
  input  wire logic              gate_pin,         // external gate pin
  input  wire logic [PORT_W-1:0] port_pins,        // digital port pin levels
  output logic                   cmp_b_on,         // comparator powered
  output logic                   cmp_b_ref_select, // plus input: 1 reference, 0 pin
  output logic      [1:0]        cmp_b_neg_input_sel, // shared minus pin select
  output logic                   cmp_b_pin_out,    // level on output pin
  output logic                   cmp_b_pin_oe_n,   // pin driver enable, low drives
  output logic                   timer_count_en,   // timer gate
  output logic                   timer_inc         // timer increment pulse
);
  cmpb_pkg::cmpb_byte_t    cmp_b_ctrl_reg;
  cmpb_pkg::cmpb_byte_t    cmp_b_aux_reg;
  logic [PORT_W-1:0]       ansel_reg;
  cmpb_pkg::cmpb_bus_state_t bus_state_reg;
  logic [31:0]             rdata_reg;
  logic                    cmp_b_registered_out;
  logic                    pin_out_reg;
  logic                    pin_oe_n_reg;
  logic                    count_en_reg;
  logic                    inc_reg;
  logic                    wait_reg;

  // external levels cross into core_clk before anything looks at them
  logic raw_lvl;
  logic tclk_lvl;
  logic tclk_rise;
  logic tclk_fall;
  logic pclk_rise;
  logic pclk_fall;
  logic gpin_lvl;
  logic dir_lvl;
  logic [PORT_W-1:0] port_m_reg;
  logic [PORT_W-1:0] port_s_reg;
  logic [3:0] misc_m_reg;
  logic [3:0] misc_s_reg;

  cmpb_edge_det u_raw (.core_clk(core_clk), .rst(rst), .din(cmp_raw),
                       .level(raw_lvl), .rise(), .fall());
  cmpb_edge_det u_tclk (.core_clk(core_clk), .rst(rst), .din(timer_clk),
                        .level(tclk_lvl), .rise(tclk_rise), .fall(tclk_fall));
  cmpb_edge_det u_pclk (.core_clk(core_clk), .rst(rst), .din(timer_presc_clk),
                        .level(), .rise(pclk_rise), .fall(pclk_fall));
  cmpb_edge_det u_gpin (.core_clk(core_clk), .rst(rst), .din(gate_pin),
                        .level(gpin_lvl), .rise(), .fall());
  cmpb_edge_det u_dir (.core_clk(core_clk), .rst(rst), .din(port_direction_bit),
                       .level(dir_lvl), .rise(), .fall());

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      port_m_reg <= '0;
      port_s_reg <= '0;
      misc_m_reg <= 4'h0;
      misc_s_reg <= 4'h0;
    end
    else
    begin
      port_m_reg <= port_pins;
      port_s_reg <= port_m_reg;
      misc_m_reg <= {cmp_a_result, timer_presc_used, timer_on, timer_gate_en};
      misc_s_reg <= misc_m_reg;
    end
  end

  wire cmp_a_lvl    = misc_s_reg[3];
  wire presc_used   = misc_s_reg[2];
  wire tmr_on_lvl   = misc_s_reg[1];
  wire gate_en_lvl  = misc_s_reg[0];

  // control fields
  wire on_bit      = cmp_b_ctrl_reg[`CMPB_BIT_ON];
  wire drive_bit   = cmp_b_ctrl_reg[`CMPB_BIT_PIN_DRIVE];
  wire invert_bit  = cmp_b_ctrl_reg[`CMPB_BIT_INVERT];
  wire gate_src    = cmp_b_aux_reg[`CMPB_BIT_GATE_SRC];
  wire sync_sel    = cmp_b_aux_reg[`CMPB_BIT_SYNC_SEL];

  // an unpowered comparator reads low before polarity is applied
  wire cmp_b_result = (on_bit & raw_lvl) ^ invert_bit;
  wire capture_edge = presc_used ? pclk_fall : tclk_fall;
  wire count_edge   = presc_used ? pclk_rise : tclk_rise;
  wire cmp_b_out    = sync_sel ? cmp_b_registered_out : cmp_b_result;
  wire gate_level   = gate_src ? gpin_lvl : cmp_b_out;
  wire gate_active  = tmr_on_lvl & gate_en_lvl;
  wire count_en_next = tmr_on_lvl & (~gate_en_lvl | gate_level);
  wire pin_en       = drive_bit & on_bit & ~dir_lvl;
  wire [PORT_W-1:0] port_read = port_s_reg & ~ansel_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cmp_b_registered_out <= 1'b0;
    else if (capture_edge)
      cmp_b_registered_out <= cmp_b_result;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out_reg  <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      count_en_reg <= 1'b0;
      inc_reg      <= 1'b0;
    end
    else
    begin
      pin_out_reg  <= pin_en & cmp_b_result;
      pin_oe_n_reg <= ~pin_en;
      count_en_reg <= count_en_next;
      inc_reg      <= count_edge & count_en_next;
    end
  end

  // bus slave: one wait cycle, answer on the second edge of the request
  // waitrequest comes from a flop and idles high; a master never sees a
  // combinational path from its own request back to the stall
  wire bus_req   = avs_read | avs_write;
  wire acc_done  = (bus_state_reg == cmpb_pkg::CMPB_ACK);
  wire wr_fire   = avs_write & acc_done & avs_byteenable[0];
  wire hit_ctrl  = (avs_address == `CMPB_OFF_CTRL);
  wire hit_aux   = (avs_address == `CMPB_OFF_AUX);
  wire hit_port  = (avs_address == `CMPB_OFF_PORT);
  wire hit_ansel = (avs_address == `CMPB_OFF_ANSEL);
  wire [7:0] wd  = avs_writedata[7:0];
  wire [7:0] ctrl_view = (cmp_b_ctrl_reg & `CMPB_CTRL_WMASK)
                         | ({7'h00, cmp_b_result} << `CMPB_BIT_RESULT);
  wire [7:0] aux_view  = (cmp_b_aux_reg & `CMPB_AUX_WMASK)
                         | ({7'h00, cmp_a_lvl} << `CMPB_BIT_MIRROR_A)
                         | ({7'h00, cmp_b_result} << `CMPB_BIT_MIRROR_B);
  // unmapped addresses read zero and ignore writes
  wire [31:0] rd_mux = hit_ctrl  ? {24'h000000, ctrl_view} :
                       hit_aux   ? {24'h000000, aux_view} :
                       hit_port  ? {{(32-PORT_W){1'b0}}, port_read} :
                       hit_ansel ? {{(32-PORT_W){1'b0}}, ansel_reg} : 32'h00000000;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_state_reg <= cmpb_pkg::CMPB_IDLE;
      wait_reg      <= 1'b1;
      rdata_reg     <= 32'h00000000;
    end
    else
    begin
      case (bus_state_reg)
        cmpb_pkg::CMPB_IDLE:
        begin
          if (bus_req)
          begin
            bus_state_reg <= cmpb_pkg::CMPB_ACK;
            wait_reg      <= 1'b0;
          end
          rdata_reg <= rd_mux;
        end
        cmpb_pkg::CMPB_ACK:
        begin
          bus_state_reg <= cmpb_pkg::CMPB_IDLE;
          wait_reg      <= 1'b1;
        end
        default:
        begin
          bus_state_reg <= cmpb_pkg::CMPB_IDLE;
          wait_reg      <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmp_b_ctrl_reg <= `CMPB_CTRL_RST;
      cmp_b_aux_reg  <= `CMPB_AUX_RST;
      ansel_reg      <= '1;
    end
    else if (wr_fire)
    begin
      if (hit_ctrl)
        cmp_b_ctrl_reg <= wd & `CMPB_CTRL_WMASK;
      if (hit_aux)
        cmp_b_aux_reg <= wd & `CMPB_AUX_WMASK;
      if (hit_ansel)
        ansel_reg <= avs_writedata[PORT_W-1:0];
    end
  end

  assign avs_waitrequest     = wait_reg;
  assign avs_readdata        = rdata_reg;
  assign cmp_b_on            = cmp_b_ctrl_reg[`CMPB_BIT_ON];
  assign cmp_b_ref_select    = cmp_b_ctrl_reg[`CMPB_BIT_REF_SEL];
  assign cmp_b_neg_input_sel = cmp_b_ctrl_reg[`CMPB_BIT_NEG_HI:`CMPB_BIT_NEG_LO];
  assign cmp_b_pin_out       = pin_out_reg;
  assign cmp_b_pin_oe_n      = pin_oe_n_reg;
  assign timer_count_en      = count_en_reg;
  assign timer_inc           = inc_reg;

  a_pin_gating: assert property (@(posedge core_clk) disable iff (rst)
    !pin_en |=> cmp_b_pin_oe_n && !cmp_b_pin_out)
    else $error("pin driven while gating is off");
  a_result_polar: assert property (@(posedge core_clk) disable iff (rst)
    cmp_b_result == ((on_bit & raw_lvl) != invert_bit))
    else $error("result polarity wrong");
  a_gate_source: assert property (@(posedge core_clk) disable iff (rst)
    (tmr_on_lvl && gate_en_lvl && !gate_src) |=> timer_count_en == $past(cmp_b_out))
    else $error("comparator does not gate timer");
  a_gate_inactive: assert property (@(posedge core_clk) disable iff (rst)
    !gate_active && tmr_on_lvl |=> timer_count_en)
    else $error("gating acted while disabled");
  a_capture_fall: assert property (@(posedge core_clk) disable iff (rst)
    !capture_edge |=> $stable(cmp_b_registered_out))
    else $error("capture outside falling edge");
  a_presc_edge: assert property (@(posedge core_clk) disable iff (rst)
    (presc_used && pclk_fall) |=> cmp_b_registered_out == $past(cmp_b_result))
    else $error("prescaled capture missed");
  a_no_same_edge: assert property (@(posedge core_clk) disable iff (rst)
    !(capture_edge && count_edge))
    else $error("capture and count on same edge");
  a_analog_read: assert property (@(posedge core_clk) disable iff (rst)
    (port_read & ansel_reg) == '0)
    else $error("analog pin reads nonzero");
  a_sync_select: assert property (@(posedge core_clk) disable iff (rst)
    sync_sel |-> cmp_b_out == cmp_b_registered_out)
    else $error("sync select wrong");
  a_bus_answer: assert property (@(posedge core_clk) disable iff (rst)
    $rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait");
  a_pin_follow: assert property (@(posedge core_clk) disable iff (rst)
    pin_en |=> !cmp_b_pin_oe_n && cmp_b_pin_out == $past(cmp_b_result))
    else $error("pin does not follow result");
  a_off_result: assert property (@(posedge core_clk) disable iff (rst)
    !on_bit |-> cmp_b_result == invert_bit)
    else $error("unpowered result not at polarity level");
  a_gate_pin: assert property (@(posedge core_clk) disable iff (rst)
    (tmr_on_lvl && gate_en_lvl && gate_src) |=> timer_count_en == $past(gpin_lvl))
    else $error("gate pin does not gate timer");
  a_raw_capture: assert property (@(posedge core_clk) disable iff (rst)
    (!presc_used && tclk_fall) |=> cmp_b_registered_out == $past(cmp_b_result))
    else $error("raw clock capture missed");
  a_inc_pulse: assert property (@(posedge core_clk) disable iff (rst)
    (count_edge && count_en_next) |=> timer_inc)
    else $error("increment missing on rising edge");
  a_count_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !count_edge |=> !timer_inc)
    else $error("increment without rising edge");
  a_ro_bits: assert property (@(posedge core_clk) disable iff (rst)
    (cmp_b_ctrl_reg & ~`CMPB_CTRL_WMASK) == 8'h00
    && (cmp_b_aux_reg & ~`CMPB_AUX_WMASK) == 8'h00)
    else $error("read-only bit stored");
  a_write_commit: assert property (@(posedge core_clk) disable iff (rst)
    (wr_fire && hit_ctrl) |=> cmp_b_ctrl_reg == ($past(wd) & `CMPB_CTRL_WMASK))
    else $error("control write did not land");
  a_unmapped_wr: assert property (@(posedge core_clk) disable iff (rst)
    (wr_fire && !hit_ctrl && !hit_aux) |=> $stable(cmp_b_ctrl_reg) && $stable(cmp_b_aux_reg))
    else $error("control changed by other write");
  a_aux_readback: assert property (@(posedge core_clk) disable iff (rst)
    (avs_read && acc_done && hit_aux) |-> avs_readdata[1:0] == cmp_b_aux_reg[1:0])
    else $error("aux read data wrong");
  c_sync_gate: cover property (@(posedge core_clk) disable iff (rst)
    sync_sel && !gate_src && gate_active && capture_edge);
  c_pin_drive: cover property (@(posedge core_clk) disable iff (rst) !cmp_b_pin_oe_n);
  c_aux_write: cover property (@(posedge core_clk) disable iff (rst) wr_fire && hit_aux);
  c_presc_capture: cover property (@(posedge core_clk) disable iff (rst) presc_used && pclk_fall);
  c_reg_read: cover property (@(posedge core_clk) disable iff (rst) avs_read && acc_done);
endmodule

// *** sim/cmpb_far_model.sv ***
// timer clock sources that stand beside comparator b: raw and prescaled clocks
// assumes the bench starts and stops each clock; a stopped clock holds its level
module cmpb_far_model
(
  input  wire logic core_clk,        // system clock
  input  wire logic rst,             // async reset, active high
  input  wire logic run_raw,         // raw timer clock runs
  input  wire logic run_presc,       // prescaled timer clock runs
  output logic      timer_clk,       // raw timer clock, period 8 cycles
  output logic      timer_presc_clk  // prescaled timer clock, period 16 cycles
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] raw_reg;
  logic [3:0] presc_reg;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      raw_reg   <= 3'h0;
      presc_reg <= 4'h0;
    end
    else
    begin
      raw_reg   <= raw_reg + 3'(run_raw);
      presc_reg <= presc_reg + 4'(run_presc);
    end
  end
  assign timer_clk       = raw_reg[2];
  assign timer_presc_clk = presc_reg[3];
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the comparator-b control block
// assumes an avalon master on core_clk and the far-side clock model
`include "cmpb_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        rst, avs_read, avs_write, avs_waitrequest, cmp_raw, dir_bit, cmp_a;
  logic        t_clk, t_pclk, presc_used, t_on, gate_en, gate_pin, run_raw, run_presc;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, junk;
  logic [7:0]  port_pins;
  logic        on, ref_sel, pin_out, pin_oe_n, count_en, inc;
  logic [1:0]  neg_sel;
  int          mismatches = 0;
  int          n_compared = 0;
  always #25 core_clk = ~core_clk;
  cmpb_far_model far (.core_clk(core_clk), .rst(rst), .run_raw(run_raw),
    .run_presc(run_presc), .timer_clk(t_clk), .timer_presc_clk(t_pclk));
  cmpb_ctrl #(.PORT_W(8)) dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmp_raw(cmp_raw), .cmp_a_result(cmp_a), .port_direction_bit(dir_bit),
    .timer_clk(t_clk), .timer_presc_clk(t_pclk), .timer_presc_used(presc_used),
    .timer_on(t_on), .timer_gate_en(gate_en), .gate_pin(gate_pin), .port_pins(port_pins),
    .cmp_b_on(on), .cmp_b_ref_select(ref_sel), .cmp_b_neg_input_sel(neg_sel),
    .cmp_b_pin_out(pin_out), .cmp_b_pin_oe_n(pin_oe_n), .timer_count_en(count_en),
    .timer_inc(inc));
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail_out();
    mismatches++;
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // request held until waitrequest is seen low; released on the accepting edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] wd,
                      output logic [31:0] rd);
    int i;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h000000, wd};
    for (i = 0; i < 20; i++)
    begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i == 20) fail_out();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, junk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 8'h00, v);
    chk(v, exp);
  endtask
  // level inputs pass two synchroniser flops
  task automatic settle(input int n = 6);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic t_reset();
    rd_chk(`CMPB_OFF_CTRL, 32'h00);
    rd_chk(`CMPB_OFF_AUX, 32'h02);
    rd_chk(4'h1, 32'h00);
    chk({on, pin_oe_n}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_polarity();
    cmp_raw <= 1'b1;
    wr(`CMPB_OFF_CTRL, 8'h80);
    settle();
    rd_chk(`CMPB_OFF_CTRL, 32'hC0);
    wr(`CMPB_OFF_CTRL, 8'h90);
    settle();
    rd_chk(`CMPB_OFF_CTRL, 32'h90);
    cmp_raw <= 1'b0;
    wr(`CMPB_OFF_CTRL, 8'hFF);
    settle();
    rd_chk(`CMPB_OFF_CTRL, 32'hF7);
    $display("polarity test done");
  endtask
  task automatic t_inputs();
    for (int k = 0; k < 4; k++)
    begin
      wr(`CMPB_OFF_CTRL, {5'h00, 1'(k), 2'(k)});
      settle(2);
      chk({ref_sel, neg_sel}, {1'(k), 2'(k)});
    end
    $display("input select test done");
  endtask
  task automatic t_pin();
    logic [7:0] d [4] = '{8'hA0, 8'hA0, 8'h20, 8'h80};
    logic [3:0] dir = 4'b0010;
    logic [3:0] oe  = 4'b1110;
    cmp_raw <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      dir_bit <= dir[k];
      wr(`CMPB_OFF_CTRL, d[k]);
      settle();
      chk(pin_oe_n, oe[k]);
      if (k == 0) chk(pin_out, 1'b1);
    end
    $display("pin test done");
  endtask
  task automatic t_gate();
    t_on    <= 1'b1;
    gate_en <= 1'b1;
    wr(`CMPB_OFF_AUX, 8'h02);
    settle();
    chk(count_en, 1'b0);
    gate_pin <= 1'b1;
    settle();
    chk(count_en, 1'b1);
    gate_pin <= 1'b0;
    wr(`CMPB_OFF_AUX, 8'h00);
    settle();
    chk(count_en, 1'b1);
    cmp_raw <= 1'b0;
    settle();
    chk(count_en, 1'b0);
    gate_en <= 1'b0;
    settle();
    chk(count_en, 1'b1);
    t_on <= 1'b0;
    settle();
    chk(count_en, 1'b0);
    t_on    <= 1'b1;
    gate_en <= 1'b1;
    $display("gate test done");
  endtask
  task automatic t_sync();
    int n = 0;
    cmp_raw <= 1'b1;
    wr(`CMPB_OFF_AUX, 8'h01);
    run_raw <= 1'b1;
    settle(40);
    chk(count_en, 1'b1);
    // stop the clock first so its last falling edge still captures a high result
    run_raw <= 1'b0;
    settle();
    cmp_raw <= 1'b0;
    settle();
    chk(count_en, 1'b1);
    run_raw <= 1'b1;
    settle(40);
    chk(count_en, 1'b0);
    presc_used <= 1'b1;
    cmp_raw    <= 1'b1;
    settle(40);
    chk(count_en, 1'b0);
    run_presc <= 1'b1;
    settle(80);
    chk(count_en, 1'b1);
    repeat (64)
    begin
      @(posedge core_clk);
      n += int'(inc === 1'b1);
    end
    chk(n, 4);
    $display("sync test done");
  endtask
  task automatic t_port();
    port_pins <= 8'hA5;
    settle();
    rd_chk(`CMPB_OFF_PORT, 32'h00);
    wr(`CMPB_OFF_ANSEL, 8'h0F);
    settle();
    rd_chk(`CMPB_OFF_PORT, 32'hA0);
    cmp_a <= 1'b1;
    settle();
    rd_chk(`CMPB_OFF_AUX, 32'hC1);
    $display("port test done");
  endtask
  task automatic t_rerst();
    cmp_a <= 1'b0;
    wr(`CMPB_OFF_CTRL, 8'hA0);
    wr(`CMPB_OFF_AUX, 8'h01);
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    rd_chk(`CMPB_OFF_CTRL, 32'h00);
    rd_chk(`CMPB_OFF_AUX, 32'h02);
    chk(pin_oe_n, 1'b1);
    $display("second reset test done");
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_out();
  end
  initial
  begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 38'h0};
    {cmp_raw, dir_bit, presc_used, t_on, gate_en, gate_pin, run_raw, run_presc} = 8'h00;
    port_pins = 8'h00;
    cmp_a = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_polarity();
    t_inputs();
    t_pin();
    t_gate();
    t_sync();
    t_port();
    t_rerst();
    wrap_up();
  end
endmodule
